// [design/periph_irq_pkg.sv]
// constants and types for the peripheral mode and interrupt configuration block
package periph_irq_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] MODE_OFS = 8'h0C;
    localparam logic [7:0] CFG_OFS = 8'h10;
    localparam logic [7:0] MASK_OFS = 8'h14;
    localparam logic [7:0] PEND_OFS = 8'h18;

    // ****************************************
    // peripheral_mode_control fields
    // ****************************************
    localparam int MODE_CLK_ON = 7;
    localparam int MODE_RESUME = 6;
    localparam int MODE_SUSPEND = 5;
    localparam int MODE_SW_RST = 4;
    localparam int MODE_GLINT = 3;
    localparam int MODE_WAKECS = 2;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] MODE_WMASK = 16'h00FC;
    localparam logic [15:0] MODE_BUS_KEEP = 16'h0008;

    // ****************************************
    // interrupt_output_config fields
    // ****************************************
    localparam int CFG_CTRL_LSB = 6;
    localparam int CFG_IN_LSB = 4;
    localparam int CFG_OUT_LSB = 2;
    localparam int CFG_LVL = 1;
    localparam int CFG_POL = 0;
    localparam logic [7:0] CFG_RST = 8'hFC;
    localparam logic [7:0] CFG_BUS_SET = 8'hFC;
    localparam logic [7:0] CFG_BUS_KEEP = 8'h03;
    localparam logic [1:0] FLT_ALL = 2'h0;
    localparam logic [1:0] FLT_ACK = 2'h1;
    localparam int FLT_FIRST_NAK = 1;

    // ****************************************
    // per-source mask and pending layout
    // ****************************************
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_WMASK = 32'h03FF_FDFF;
    localparam logic [31:0] MASK_BUS_KEEP = 32'h0000_0001;
    localparam logic [4:0] EP_IRQ_BASE = 5'h0A;
    localparam int SETUP_BIT = 8;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_FREQ_KHZ = 20000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SUSP_DELAY_MS = 2;
    localparam int RES_DELAY_MS = 5;
    localparam int RES_DRIVE_MS = 10;
    localparam int IRQ_PULSE_NS = 60;
    localparam int SUSP_DELAY_CYC = SUSP_DELAY_MS * CLK_FREQ_KHZ;
    localparam int RES_DELAY_CYC = RES_DELAY_MS * CLK_FREQ_KHZ;
    localparam int RES_DRIVE_CYC = RES_DRIVE_MS * CLK_FREQ_KHZ;
    localparam int PULSE_CYC = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_W = 2;
    localparam int TMR_W = 18;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {HS_ACK = 2'h0, HS_NAK = 2'h1, HS_NYET = 2'h2} hs_kind_t;
    typedef enum logic [2:0] {S_ACTIVE = 3'h1, S_SUSP = 3'h2, S_STOP = 3'h4} susp_state_t;
    typedef enum logic [2:0] {R_IDLE = 3'h1, R_WAIT = 3'h2, R_DRIVE = 3'h4} res_state_t;

endpackage

// [design/cycle_timer.sv]
// one-shot down counter that pulses when a loaded count expires
`timescale 1ns/10ps
module cycle_timer #(
    parameter int W = 18
) (
    // clock and reset
    input logic ref_clk_i,
    input logic rst_b_i,
    // control
    input logic start_i,
    input logic clear_i,
    input logic [W-1:0] count_i,
    // status
    output logic busy_o,
    output logic done_o
);

    logic [W-1:0] cnt_r;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            cnt_r <= '0;
        else if (start_i)
            cnt_r <= count_i;
        else if (clear_i)
            cnt_r <= '0;
        else if (cnt_r != '0)
            cnt_r <= cnt_r - 1'b1;
    end

    // a restart or clear in the last cycle swallows the expiry
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            done_o <= 1'b0;
        else
            done_o <= (cnt_r == W'(1)) && !start_i && !clear_i;
    end

    assign busy_o = (cnt_r != '0);

endmodule

// [design/periph_mode_irq.sv]
// suspend, resume, soft reset and interrupt output logic of the peripheral controller
// Notes on behaviour
// - clock-always-on clear: suspend stops the clock about 2 ms later
// - clock-always-on set: suspend is entered but the clock never stops
// - send-resume one-then-zero: wait 5 ms, then drive resume for 10 ms
// - go-suspend one-then-zero enters suspend mode
// - soft-reset one-then-zero resets the block like the reset pin
// - global enable low keeps the interrupt output inactive
// - enabling globally with an unmasked pending source asserts the output at once
// - pulse mode may drop events seen while global enable was low
// - wake-on-chip-select: a register read restarts the stopped clock
// - polarity bit: 0 active low, 1 active high; kept over bus reset
// - level bit: 0 level, 1 pulse of two 50 ns cycles (at least 60 ns); kept over bus reset
// - endpoint interrupts come from ACK, NAK or NYET, filtered per field
// - filter field by traffic: control ep0, data IN, data OUT
// - filter 00: all ACK and NAK, plus NYET on data OUT
// - filter 01: ACK only, plus NYET on data OUT, never NAK
// - filter 1x: all ACK (and NYET on data OUT) and first NAK after ACK
// - bus reset clears all source enables except bus-reset enable
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
module periph_mode_irq
    import periph_irq_pkg::*;
#(
    parameter int SUSP_CYC = SUSP_DELAY_CYC,
    parameter int RES_WAIT_CYC = RES_DELAY_CYC,
    parameter int RES_SIG_CYC = RES_DRIVE_CYC
) (
    // clock and reset
    input logic ref_clk_i,
    input logic rst_b_i,
    // register port
    input logic [ADDR_W-1:0] addr_i,
    input logic [DATA_W-1:0] wdata_i,
    input logic wr_i,
    input logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    // serial interface engine events
    input logic hs_valid_i,
    input logic [1:0] hs_kind_i,
    input logic [2:0] hs_ep_i,
    input logic hs_in_i,
    input logic setup_evt_i,
    input logic [7:0] bus_evt_i,
    input logic usb_bus_reset_i,
    input logic usb_resume_i,
    // outputs
    output logic irq_o,
    output logic suspended_o,
    output logic clk_stop_o,
    output logic resume_drive_o,
    output logic soft_reset_o
);

    // ****************************************
    // decode and command detection
    // ****************************************
    function automatic logic fell(input logic [15:0] old_v, input logic [15:0] new_v,
                                  input int pos);
        return old_v[pos] & ~new_v[pos];
    endfunction

    function automatic logic hs_pass(input logic [1:0] mode, input logic [1:0] kind,
                                     input logic is_out, input logic first_nak);
        logic ack_like;
        logic nak;
        ack_like = (kind == HS_ACK) || (is_out && kind == HS_NYET);
        nak = (kind == HS_NAK);
        if (mode[FLT_FIRST_NAK])
            return ack_like || (nak && first_nak);
        else if (mode == FLT_ALL)
            return ack_like || nak;
        else
            return ack_like;
    endfunction

    logic soft_rst_r;
    logic core_rst_b;
    logic [15:0] mode_r;
    logic [7:0] cfg_r;
    logic [31:0] mask_r;
    logic [31:0] pend_r;
    logic [15:0] nak_seen_r;
    logic glint_prev_r;
    logic [PULSE_W-1:0] pulse_cnt_r;
    logic wr_mode;
    logic wr_cfg;
    logic wr_mask;
    logic wr_pend;
    logic go_susp_fire;
    logic send_res_fire;
    logic sw_rst_fire;
    logic glint;
    logic clk_on;
    logic lvl;
    logic pol;

    assign wr_mode = wr_i && (addr_i == MODE_OFS);
    assign wr_cfg = wr_i && (addr_i == CFG_OFS);
    assign wr_mask = wr_i && (addr_i == MASK_OFS);
    assign wr_pend = wr_i && (addr_i == PEND_OFS);
    // only a falling write acts, so a bit left at one repeats nothing
    assign go_susp_fire = wr_mode && fell(mode_r, wdata_i[15:0], MODE_SUSPEND);
    assign send_res_fire = wr_mode && fell(mode_r, wdata_i[15:0], MODE_RESUME);
    assign sw_rst_fire = wr_mode && fell(mode_r, wdata_i[15:0], MODE_SW_RST);
    assign glint = mode_r[MODE_GLINT];
    assign clk_on = mode_r[MODE_CLK_ON];
    assign lvl = cfg_r[CFG_LVL];
    assign pol = cfg_r[CFG_POL];

    // ****************************************
    // soft reset
    // ****************************************
    // one-cycle pulse held only by the pin reset, so it cannot reset itself
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            soft_rst_r <= 1'b0;
        else
            soft_rst_r <= sw_rst_fire;
    end

    assign core_rst_b = rst_b_i && !soft_rst_r;
    assign soft_reset_o = soft_rst_r;

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (!core_rst_b)
            mode_r <= MODE_RST;
        else if (wr_mode)
            mode_r <= wdata_i[15:0] & MODE_WMASK;
        else if (usb_bus_reset_i)
            mode_r <= mode_r & MODE_BUS_KEEP;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!core_rst_b)
            cfg_r <= CFG_RST;
        else if (wr_cfg)
            cfg_r <= wdata_i[7:0];
        else if (usb_bus_reset_i)
            cfg_r <= (cfg_r & CFG_BUS_KEEP) | CFG_BUS_SET;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!core_rst_b)
            mask_r <= MASK_RST;
        else if (wr_mask)
            mask_r <= wdata_i & MASK_WMASK;
        else if (usb_bus_reset_i)
            mask_r <= mask_r & MASK_BUS_KEEP;
    end

    // ****************************************
    // handshake filtering
    // ****************************************
    logic [1:0] fld;
    logic is_out;
    logic [3:0] nak_idx;
    logic [4:0] ep_bit;
    logic hs_ok;
    logic [31:0] set_vec;

    always_comb
    begin
        if (hs_ep_i == 3'h0)
            fld = cfg_r[CFG_CTRL_LSB +: 2];
        else if (hs_in_i)
            fld = cfg_r[CFG_IN_LSB +: 2];
        else
            fld = cfg_r[CFG_OUT_LSB +: 2];
    end

    assign is_out = (hs_ep_i != 3'h0) && !hs_in_i;
    assign nak_idx = {hs_ep_i, hs_in_i};
    assign ep_bit = EP_IRQ_BASE + {1'b0, nak_idx};
    assign hs_ok = hs_valid_i && hs_pass(fld, hs_kind_i, is_out, !nak_seen_r[nak_idx]);

    always_comb
    begin
        set_vec = '0;
        set_vec[7:0] = bus_evt_i;
        set_vec[SETUP_BIT] = setup_evt_i;
        if (hs_ok)
            set_vec[ep_bit] = 1'b1;
    end

    // a NAK is "first" again only after an ACK on the same endpoint direction
    always_ff @(posedge ref_clk_i)
    begin
        if (!core_rst_b)
            nak_seen_r <= '0;
        else if (hs_valid_i && hs_kind_i == HS_ACK)
            nak_seen_r[nak_idx] <= 1'b0;
        else if (hs_valid_i && hs_kind_i == HS_NAK)
            nak_seen_r[nak_idx] <= 1'b1;
    end

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge ref_clk_i)
    begin
        if (!core_rst_b)
            pend_r <= '0;
        else
            pend_r <= ((pend_r & ~(wr_pend ? wdata_i : 32'h0000_0000)) | set_vec) & MASK_WMASK;
    end

    // ****************************************
    // interrupt output
    // ****************************************
    logic active_any;
    logic pulse_start;
    logic irq_act;

    assign active_any = |(pend_r & mask_r);
    // events while disabled are not replayed, only a pending one on enable
    assign pulse_start = glint && (|(set_vec & mask_r) || (!glint_prev_r && active_any));
    assign irq_act = lvl ? (pulse_cnt_r != '0) : (glint && active_any);

    always_ff @(posedge ref_clk_i)
    begin
        if (!core_rst_b)
            glint_prev_r <= 1'b0;
        else
            glint_prev_r <= glint;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!core_rst_b)
            pulse_cnt_r <= '0;
        else if (pulse_start && lvl)
            pulse_cnt_r <= PULSE_W'(PULSE_CYC);
        else if (pulse_cnt_r != '0)
            pulse_cnt_r <= pulse_cnt_r - 1'b1;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!core_rst_b)
            irq_o <= 1'b1;
        else
            irq_o <= pol ? irq_act : !irq_act;
    end

    // ****************************************
    // suspend control
    // ****************************************
    susp_state_t susp_state_r;
    susp_state_t susp_nxt;
    logic wake;
    logic susp_done;
    res_state_t res_state_r;

    // the reference clock is assumed free running; clk_stop_o gates the core
    assign wake = usb_resume_i || (res_state_r == R_DRIVE)
                  || (mode_r[MODE_WAKECS] && rd_i);

    always_comb
    begin
        susp_nxt = susp_state_r;
        case (susp_state_r)
            S_ACTIVE:
                if (go_susp_fire)
                    susp_nxt = S_SUSP;
            S_SUSP:
                if (wake)
                    susp_nxt = S_ACTIVE;
                else if (susp_done && !clk_on)
                    susp_nxt = S_STOP;
            S_STOP:
                if (wake)
                    susp_nxt = S_ACTIVE;
                else if (clk_on)
                    susp_nxt = S_SUSP;
            default:
                susp_nxt = S_ACTIVE;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!core_rst_b)
        begin
            susp_state_r <= S_ACTIVE;
            suspended_o <= 1'b0;
            clk_stop_o <= 1'b0;
        end
        else
        begin
            susp_state_r <= susp_nxt;
            suspended_o <= (susp_nxt != S_ACTIVE);
            clk_stop_o <= (susp_nxt == S_STOP);
        end
    end

    cycle_timer #(.W(TMR_W)) u_susp_tmr (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(core_rst_b),
        .start_i(go_susp_fire && susp_state_r == S_ACTIVE),
        .clear_i(wake),
        .count_i(TMR_W'(SUSP_CYC)),
        .busy_o(),
        .done_o(susp_done)
    );

    // ****************************************
    // resume signalling
    // ****************************************
    res_state_t res_nxt;
    logic res_start;
    logic res_done;

    assign res_start = (res_state_r == R_IDLE && send_res_fire)
                       || (res_state_r == R_WAIT && res_done);

    always_comb
    begin
        res_nxt = res_state_r;
        case (res_state_r)
            R_IDLE:
                if (send_res_fire)
                    res_nxt = R_WAIT;
            R_WAIT:
                if (res_done)
                    res_nxt = R_DRIVE;
            R_DRIVE:
                if (res_done)
                    res_nxt = R_IDLE;
            default:
                res_nxt = R_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!core_rst_b)
        begin
            res_state_r <= R_IDLE;
            resume_drive_o <= 1'b0;
        end
        else
        begin
            res_state_r <= res_nxt;
            resume_drive_o <= (res_nxt == R_DRIVE);
        end
    end

    cycle_timer #(.W(TMR_W)) u_res_tmr (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(core_rst_b),
        .start_i(res_start),
        .clear_i(1'b0),
        .count_i(res_state_r == R_IDLE ? TMR_W'(RES_WAIT_CYC) : TMR_W'(RES_SIG_CYC)),
        .busy_o(),
        .done_o(res_done)
    );

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (!core_rst_b || !rd_i)
            rdata_o <= '0;
        else
            case (addr_i)
                MODE_OFS: rdata_o <= {16'h0000, mode_r};
                CFG_OFS: rdata_o <= {24'h00_0000, cfg_r};
                MASK_OFS: rdata_o <= mask_r;
                PEND_OFS: rdata_o <= pend_r;
                default: rdata_o <= '0;
            endcase
    end

    // ****************************************
    // checks
    // ****************************************
    property p_susp_start;
        @(posedge ref_clk_i) disable iff (!core_rst_b)
        (go_susp_fire && susp_state_r == S_ACTIVE && !clk_on) |=>
            (susp_state_r == S_SUSP && !clk_stop_o);
    endproperty
    a_susp_start: assert property (p_susp_start) else $error("suspend entry wrong");

    property p_clk_on;
        @(posedge ref_clk_i) disable iff (!core_rst_b)
        clk_on |=> !clk_stop_o;
    endproperty
    a_clk_on: assert property (p_clk_on) else $error("clock stopped while always on");

    property p_resume;
        @(posedge ref_clk_i) disable iff (!core_rst_b)
        (send_res_fire && res_state_r == R_IDLE) |=> (res_state_r == R_WAIT && !resume_drive_o);
    endproperty
    a_resume: assert property (p_resume) else $error("resume did not wait");

    property p_go_susp;
        @(posedge ref_clk_i) disable iff (!core_rst_b)
        (go_susp_fire && susp_state_r == S_ACTIVE) |=> suspended_o;
    endproperty
    a_go_susp: assert property (p_go_susp) else $error("suspend not entered");

    property p_soft_rst;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        sw_rst_fire |=> soft_rst_r ##1 (mode_r == MODE_RST && !suspended_o);
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset missing");

    property p_glint_off;
        @(posedge ref_clk_i) disable iff (!core_rst_b)
        (!glint && pulse_cnt_r == '0) |=> (irq_o == !$past(pol));
    endproperty
    a_glint_off: assert property (p_glint_off) else $error("irq while disabled");

    property p_glint_on;
        @(posedge ref_clk_i) disable iff (!core_rst_b)
        ($rose(glint) && !lvl && active_any) |=> (irq_o == $past(pol));
    endproperty
    a_glint_on: assert property (p_glint_on) else $error("irq late on enable");

    property p_wake_cs;
        @(posedge ref_clk_i) disable iff (!core_rst_b)
        (susp_state_r == S_STOP && mode_r[MODE_WAKECS] && rd_i) |=> (!clk_stop_o && !suspended_o);
    endproperty
    a_wake_cs: assert property (p_wake_cs) else $error("read did not wake");

    property p_cfg_keep;
        @(posedge ref_clk_i) disable iff (!core_rst_b)
        (usb_bus_reset_i && !wr_cfg) |=> (cfg_r == ($past(cfg_r) & CFG_BUS_KEEP | CFG_BUS_SET));
    endproperty
    a_cfg_keep: assert property (p_cfg_keep) else $error("config bus reset wrong");

    property p_pulse;
        @(posedge ref_clk_i) disable iff (!core_rst_b)
        (pulse_start && lvl) |=> (pulse_cnt_r != '0) [*2];
    endproperty
    a_pulse: assert property (p_pulse) else $error("irq pulse too short");

    property p_ack_irq;
        @(posedge ref_clk_i) disable iff (!core_rst_b)
        (hs_valid_i && hs_kind_i == HS_ACK) |=> pend_r[$past(ep_bit)];
    endproperty
    a_ack_irq: assert property (p_ack_irq) else $error("ack lost");

    property p_nak_masked;
        @(posedge ref_clk_i) disable iff (!core_rst_b)
        (hs_valid_i && hs_kind_i == HS_NAK && fld == FLT_ACK && !pend_r[ep_bit])
            |=> !pend_r[$past(ep_bit)];
    endproperty
    a_nak_masked: assert property (p_nak_masked) else $error("nak not filtered");

    property p_mask_bus;
        @(posedge ref_clk_i) disable iff (!core_rst_b)
        (usb_bus_reset_i && !wr_mask) |=> (mask_r == ($past(mask_r) & MASK_BUS_KEEP));
    endproperty
    a_mask_bus: assert property (p_mask_bus) else $error("mask bus reset wrong");

endmodule

// [tb/cpu_host_model.sv]
// host processor model driving the plain register port
`timescale 1ns/10ps
module cpu_host_model
    import periph_irq_pkg::*;
#(
    parameter int STABLE_CYC = 8
) (
    // clock
    input wire logic ref_clk_i,
    // register port
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [DATA_W-1:0] rdata_i
);
    // ****************************************
    // bus cycles
    // ****************************************
    logic [1:0] hw_copy;

    initial
    begin
        addr_o = '0;
        wdata_o = '0;
        wr_o = 1'b0;
        rd_o = 1'b0;
        hw_copy = 2'h0;
    end

    // one idle edge after each write so a strobe is never set and cleared in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        if (a == CFG_OFS)
            hw_copy = d[1:0];
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge ref_clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        @(posedge ref_clk_i);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge ref_clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        @(posedge ref_clk_i);
        d = rdata_i;
    endtask

    // no write until the restarted clock has settled
    task automatic wake_rd(input logic [7:0] a, output logic [31:0] d);
        rd(a, d);
        repeat (STABLE_CYC) @(posedge ref_clk_i);
    endtask
endmodule

// [tb/periph_mode_irq_tb.sv]
// self-checking bench for the mode and interrupt configuration block
`timescale 1ns/10ps
module periph_mode_irq_tb
    import periph_irq_pkg::*;
;
    // ****************************************
    // signals and instances
    // ****************************************
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, v;
    logic wr, rd, irq, susp, stop, rdrv, srst, hi;
    logic hs_valid = 1'b0, hs_in = 1'b0, bus_rst = 1'b0, resume = 1'b0;
    logic [1:0] hs_kind = 2'h0, k;
    logic [2:0] hs_ep = 3'h0;
    logic [7:0] cfg_r;
    logic armed [16];
    int err_count = 0, checked = 0, seed = 32'h4cd8_f72e, n, r;
    // nak, nak, ack, nak, nak on one endpoint in first-nak mode
    logic [1:0] k_seq [5] = '{HS_NAK, HS_NAK, HS_ACK, HS_NAK, HS_NAK};

    always #25 ref_clk_i = ~ref_clk_i;

    cpu_host_model host (.ref_clk_i(ref_clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
        .rd_o(rd), .rdata_i(rdata));

    periph_mode_irq #(.SUSP_CYC(20), .RES_WAIT_CYC(30), .RES_SIG_CYC(40)) dut (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .hs_valid_i(hs_valid), .hs_kind_i(hs_kind),
        .hs_ep_i(hs_ep), .hs_in_i(hs_in), .setup_evt_i(1'b0), .bus_evt_i(8'h00),
        .usb_bus_reset_i(bus_rst), .usb_resume_i(resume), .irq_o(irq), .suspended_o(susp),
        .clk_stop_o(stop), .resume_drive_o(rdrv), .soft_reset_o(srst));

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    // bounded wait on clock stop (sel 0) or resume drive (sel 1)
    task automatic wait_lvl(input int sel, input logic lvl);
        n = 0;
        while ((sel == 0 ? stop : rdrv) !== lvl && n < 300)
        begin
            @(posedge ref_clk_i);
            n++;
        end
        if (n >= 300)
        begin
            err_count++;
            final_report();
        end
    endtask

    task automatic ev(input logic [1:0] kd, input logic [2:0] ep, input logic dir);
        hs_valid <= 1'b1;
        hs_kind <= kd;
        hs_ep <= ep;
        hs_in <= dir;
        @(posedge ref_clk_i);
        hs_valid <= 1'b0;
    endtask

    task automatic one(input logic [1:0] kd, input logic [2:0] ep, input logic dir);
        int i;
        logic [1:0] f;
        logic e;
        logic [31:0] p;
        i = 2 * ep + dir;
        f = (ep == 3'h0) ? cfg_r[7:6] : (dir ? cfg_r[5:4] : cfg_r[3:2]);
        e = (kd == HS_ACK) | (kd == HS_NYET && ep != 3'h0 && !dir)
            | (kd == HS_NAK && (f == FLT_ALL || (f[FLT_FIRST_NAK] && armed[i])));
        if (kd != HS_NYET)
            armed[i] = (kd == HS_ACK);
        host.wr(PEND_OFS, 32'hFFFF_FFFF);
        ev(kd, ep, dir);
        host.rd(PEND_OFS, p);
        chkb(p[EP_IRQ_BASE + i], e);
    endtask

    initial
    begin
        repeat (100000) @(posedge ref_clk_i);
        err_count++;
        final_report();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        for (int i = 0; i < 16; i++)
            armed[i] = 1'b1;
        repeat (5) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        @(posedge ref_clk_i);
        chkb(irq, 1'b1);
        host.rd(CFG_OFS, v);
        chk(v, 32'h0000_00FC);
        host.rd(8'h20, v);
        chk(v, 32'h0000_0000);
        $display("done reset");
        host.wr(MASK_OFS, 32'h0000_2000);
        host.wr(MODE_OFS, 32'h0000_0008);
        ev(HS_ACK, 3'h1, 1'b1);
        @(posedge ref_clk_i);
        chkb(irq, 1'b1);
        @(posedge ref_clk_i);
        chkb(irq, 1'b0);
        host.wr(MODE_OFS, 32'h0000_0000);
        repeat (2) @(posedge ref_clk_i);
        chkb(irq, 1'b1);
        host.wr(MODE_OFS, 32'h0000_0008);
        repeat (2) @(posedge ref_clk_i);
        chkb(irq, 1'b0);
        host.wr(CFG_OFS, 32'h0000_00FD);
        repeat (2) @(posedge ref_clk_i);
        chkb(irq, 1'b1);
        host.wr(PEND_OFS, 32'hFFFF_FFFF);
        host.wr(CFG_OFS, 32'h0000_00FE);
        repeat (2) @(posedge ref_clk_i);
        chkb(irq, 1'b1);
        ev(HS_ACK, 3'h1, 1'b1);
        n = 0;
        repeat (6)
        begin
            @(posedge ref_clk_i);
            n += (irq === 1'b0);
        end
        chk(n, 2);
        $display("done irq output");
        cfg_r = 8'hFC;
        host.wr(CFG_OFS, {24'h0, cfg_r});
        foreach (k_seq[j])
            one(k_seq[j], 3'h2, 1'b0);
        // first half keeps every field in first-nak mode so the armed history stays exact
        for (int s = 0; s < 80; s++)
        begin
            r = $random(seed);
            hi = (s < 40);
            cfg_r = {hi, r[0], hi, r[1], hi, r[2], 2'b00};
            host.wr(CFG_OFS, {24'h0, cfg_r});
            k = (r[9:8] == 2'h3) ? 2'h0 : r[9:8];
            one(k, r[6:4], r[7]);
            if (k == HS_NYET)
                one(HS_ACK, r[6:4], r[7]);
        end
        $display("done filters");
        host.wr(MASK_OFS, 32'h03FF_FDFF);
        host.wr(CFG_OFS, 32'h0000_0003);
        host.wr(MODE_OFS, 32'h0000_000C);
        bus_rst <= 1'b1;
        @(posedge ref_clk_i);
        bus_rst <= 1'b0;
        @(posedge ref_clk_i);
        host.rd(MASK_OFS, v);
        chk(v, 32'h0000_0001);
        host.rd(CFG_OFS, v);
        chk(v, 32'h0000_00FF);
        chk(v[1:0], host.hw_copy);
        $display("done bus reset");
        host.wr(MODE_OFS, 32'h0000_0024);
        host.wr(MODE_OFS, 32'h0000_0024);
        chkb(susp, 1'b0);
        host.wr(MODE_OFS, 32'h0000_0004);
        chkb(susp, 1'b1);
        wait_lvl(0, 1'b1);
        chkb(n >= 16 && n <= 25, 1'b1);
        host.wake_rd(MODE_OFS, v);
        chkb(susp, 1'b0);
        host.wr(MODE_OFS, 32'h0000_00A4);
        host.wr(MODE_OFS, 32'h0000_0084);
        repeat (30) @(posedge ref_clk_i);
        chkb(susp, 1'b1);
        chkb(stop, 1'b0);
        resume <= 1'b1;
        @(posedge ref_clk_i);
        resume <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        chkb(susp, 1'b0);
        $display("done suspend");
        host.wr(MODE_OFS, 32'h0000_0044);
        host.wr(MODE_OFS, 32'h0000_0004);
        wait_lvl(1, 1'b1);
        chkb(n >= 26 && n <= 36, 1'b1);
        wait_lvl(1, 1'b0);
        chkb(n >= 36 && n <= 46, 1'b1);
        $display("done resume");
        host.wr(CFG_OFS, 32'h0000_0055);
        host.wr(MODE_OFS, 32'h0000_0014);
        host.wr(MODE_OFS, 32'h0000_0004);
        chkb(srst, 1'b1);
        @(posedge ref_clk_i);
        host.rd(CFG_OFS, v);
        chk(v, 32'h0000_00FC);
        host.rd(MODE_OFS, v);
        chk(v, 32'h0000_0000);
        $display("done soft reset");
        final_report();
    end
endmodule
